// ---- rtl/ret_rot_exec.sv ----
// Executor for the return, return-with-immediate and rotate-through-carry instructions
module ret_rot_exec
  import ret_rot_pkg::*;
#(
  parameter int DEPTH = ret_rot_pkg::STACK_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [ret_rot_pkg::INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [ret_rot_pkg::DATA_W-1:0] file_rdata_i,
  input wire logic push_i,
  input wire logic [ret_rot_pkg::PC_W-1:0] push_addr_i,
  output logic instr_ready_o,
  output logic [ret_rot_pkg::FADDR_W-1:0] file_addr_o,
  output logic file_we_o,
  output logic [ret_rot_pkg::DATA_W-1:0] file_wdata_o,
  output logic [ret_rot_pkg::DATA_W-1:0] acc_o,
  output logic carry_o,
  output logic [ret_rot_pkg::PC_W-1:0] pc_o,
  output logic pc_load_o,
  output logic [ret_rot_pkg::SP_W-1:0] sp_o
);
  import ret_rot_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic carry;
    logic [PC_W-1:0] pc;
    logic pc_load;
    logic [SP_W-1:0] sp;
    logic busy;
    logic fwe;
    logic [DATA_W-1:0] fwdata;
  } state_type;

  state_type s_q, s_d;
  logic [PC_W-1:0] stack_q [DEPTH];
  op_type op;
  logic left;
  logic [DATA_W-1:0] rot_res;
  logic rot_c;
  logic [SP_W-1:0] top_idx;

  // ==========================================================
  // Decode
  // Only a valid word outside the second return cycle is acted on
  always_comb begin
    op = OP_NONE;
    if (instr_valid_i && !s_q.busy) begin
      if (instr_i == OPC_RETURN) begin
        op = OP_RET;
      end else if (instr_i[13:10] == OPC_RETIMM_HI) begin
        op = OP_RETIMM;
      end else if (instr_i[13:8] == OPC_ROTL || instr_i[13:8] == OPC_ROTR) begin
        op = OP_ROT;
      end else begin
        op = OP_NONE; // Other encodings are ignored
      end
    end
  end

  // Direction select for the rotate datapath
  assign left = (instr_i[13:8] == OPC_ROTL);
  assign file_addr_o = instr_i[FADDR_W-1:0];
  assign top_idx = s_q.sp - 3'd1;
  assign instr_ready_o = !s_q.busy;

  rot_carry_unit #(.WIDTH(DATA_W)) u_rot (
    .value_i(file_rdata_i),
    .carry_i(s_q.carry),
    .left_i(left),
    .result_o(rot_res),
    .carry_o(rot_c)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pc_load = 1'b0;
    s_d.fwe = 1'b0;
    // A push is refused in the second cycle of a return
    if (push_i && !s_q.busy) begin
      s_d.sp = s_q.sp + 3'd1;
    end
    if (s_q.busy) begin
      s_d.busy = 1'b0; // second cycle
    end else begin
      case (op)
        OP_RET, OP_RETIMM: begin
          s_d.pc = stack_q[top_idx];
          s_d.pc_load = 1'b1;
          s_d.sp = top_idx;
          s_d.busy = 1'b1;
          if (op == OP_RETIMM) s_d.acc = instr_i[DATA_W-1:0];
        end
        OP_ROT: begin
          s_d.carry = rot_c;
          if (instr_i[DEST_BIT]) begin
            s_d.fwe = 1'b1;
            s_d.fwdata = rot_res;
          end else begin
            s_d.acc = rot_res;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '{acc: ACC_RST, carry: CARRY_RST, pc: PC_RST, pc_load: 1'b0, sp: SP_RST,
               busy: 1'b0, fwe: 1'b0, fwdata: ACC_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // Return stack storage; entries are not reset, only the pointer is
  always_ff @(posedge clk_i) begin
    if (push_i && !s_q.busy) begin
      stack_q[s_q.sp] <= push_addr_i;
    end
  end

  assign acc_o = s_q.acc;
  assign carry_o = s_q.carry;
  assign pc_o = s_q.pc;
  assign pc_load_o = s_q.pc_load;
  assign sp_o = s_q.sp;
  assign file_we_o = s_q.fwe;
  assign file_wdata_o = s_q.fwdata;

  // ==========================================================
  // Checks
  ret_imm_acc_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (instr_valid_i && !s_q.busy && instr_i[13:10] == OPC_RETIMM_HI) |=> acc_o == $past(instr_i[7:0]))
    else $error("accumulator not loaded with immediate");
  ret_imm_pc_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_RETIMM) |=> pc_load_o && sp_o == $past(top_idx))
    else $error("immediate return did not pop");
  ret_imm_two_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_RETIMM) |=> !instr_ready_o ##1 instr_ready_o && $stable(carry_o))
    else $error("immediate return not two cycles");
  ret_plain_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_RET) |=> pc_load_o && !instr_ready_o && $stable(carry_o) && $stable(acc_o))
    else $error("plain return misbehaved");
  rot_left_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && left) |=> carry_o == $past(file_rdata_i[7]))
    else $error("left rotate carry wrong");
  rot_right_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && !left) |=> carry_o == $past(file_rdata_i[0]))
    else $error("right rotate carry wrong");
  rot_dest_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT) |=> file_we_o == $past(instr_i[DEST_BIT]))
    else $error("rotate destination wrong");
  rot_fill_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && left && instr_i[DEST_BIT]) |=> file_wdata_o[0] == $past(s_q.carry))
    else $error("old carry not in bit 0");

  // ==========================================================
  // Rotate results, by direction and destination
  rot_left_acc_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && left && !instr_i[DEST_BIT]) |=>
      acc_o == {$past(file_rdata_i[6:0]), $past(carry_o)} && !file_we_o)
    else $error("left rotate result not in accumulator");
  rot_right_acc_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && !left && !instr_i[DEST_BIT]) |=>
      acc_o == {$past(carry_o), $past(file_rdata_i[7:1])} && !file_we_o)
    else $error("right rotate result not in accumulator");
  rot_left_word_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && left && instr_i[DEST_BIT]) |=>
      file_wdata_o == {$past(file_rdata_i[6:0]), $past(carry_o)})
    else $error("left rotate write data wrong");
  rot_right_fill_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && !left && instr_i[DEST_BIT]) |=>
      file_wdata_o == {$past(carry_o), $past(file_rdata_i[7:1])})
    else $error("right rotate write data wrong");

  // Rotates to the file leave the accumulator and program counter alone
  rot_keep_acc_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT && instr_i[DEST_BIT]) |=> $stable(acc_o))
    else $error("file rotate touched accumulator");
  rot_keep_pc_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_ROT) |=> !pc_load_o && $stable(pc_o))
    else $error("rotate touched program counter");

  // Returns pop exactly one entry and touch no flag
  ret_pop_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_RET) |=> sp_o == $past(sp_o) - 3'd1 && !file_we_o)
    else $error("plain return did not pop one entry");
  ret_imm_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (op == OP_RETIMM) |=> $stable(carry_o) && !file_we_o)
    else $error("immediate return changed flags");

  // Second return cycle refuses pushes and new loads
  push_busy_a: assert property (@(posedge clk_i) disable iff (srst_i)
    s_q.busy |=> $stable(sp_o) && !pc_load_o)
    else $error("stack moved in second return cycle");
  pc_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
    pc_load_o |=> !pc_load_o)
    else $error("program counter load longer than one cycle");
endmodule : ret_rot_exec

// ---- pkg/ret_rot_pkg.sv ----
// Package: encodings, widths and reset values for the return and rotate executor
package ret_rot_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int INSTR_W = 14;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  // Opcode fields (14-bit words)
  localparam logic [13:0] OPC_RETURN = 14'h0008;
  localparam logic [3:0] OPC_RETIMM_HI = 4'hD; // bits 13:10 = 4'b1101
  localparam logic [5:0] OPC_ROTL = 6'h0D; // bits 13:8
  localparam logic [5:0] OPC_ROTR = 6'h0C; // bits 13:8
  localparam int DEST_BIT = 7;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic CARRY_RST = 1'b0;
  // Cycle counts
  localparam int RET_CYCLES = 2;
  localparam int ROT_CYCLES = 1;
  typedef enum logic [1:0] {OP_NONE, OP_RET, OP_RETIMM, OP_ROT} op_type;
endpackage : ret_rot_pkg

// ---- rtl/rot_carry_unit.sv ----
// Rotate-through-carry datapath for both directions
module rot_carry_unit #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] value_i,
  input wire logic carry_i,
  input wire logic left_i,
  output logic [WIDTH-1:0] result_o,
  output logic carry_o
);
  // Left: carry into bit 0, bit 7 out; right: carry into bit 7, bit 0 out
  always_comb begin
    if (left_i) begin
      result_o = {value_i[WIDTH-2:0], carry_i};
      carry_o = value_i[WIDTH-1];
    end else begin
      result_o = {carry_i, value_i[WIDTH-1:1]};
      carry_o = value_i[0];
    end
  end
endmodule : rot_carry_unit

// ---- sim/prog_mem_model.sv ----
// Program memory model handing instruction words to the executor
module prog_mem_model
  import ret_rot_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ready_i,
  input wire logic stall_i,
  output logic [INSTR_W-1:0] instr_o,
  output logic valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [INSTR_W-1:0] words[$];
  initial begin
    instr_o = '0;
    valid_o = 1'b0;
  end
  // ==========
  // Fetch: hold a word until taken, scramble the bus while idle
  always @(posedge clk_i) begin
    if (srst_i) begin
      valid_o <= 1'b0;
    end else if (!valid_o || ready_i) begin
      if (stall_i || words.size() == 0) begin
        valid_o <= 1'b0;
        instr_o <= ~instr_o;
      end else begin
        valid_o <= 1'b1;
        instr_o <= words.pop_front();
      end
    end
  end
endmodule : prog_mem_model

// ---- sim/ret_rot_exec_tb_top.sv ----
// Self-checking bench for the return and rotate executor
module ret_rot_exec_tb_top;
  import ret_rot_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, srst_i = 1'b1, push_i = 1'b0, stall_i = 1'b0, took = 1'b0;
  logic [PC_W-1:0] push_addr_i = '0, pc_o, pc_m = PC_RST, stk[8];
  logic [INSTR_W-1:0] instr_i;
  logic instr_valid_i, instr_ready_o, file_we_o, carry_o, pc_load_o, carry_m = CARRY_RST;
  logic [FADDR_W-1:0] file_addr_o;
  logic [DATA_W-1:0] file_wdata_o, acc_o, acc_m = ACC_RST, fmem[128];
  logic [SP_W-1:0] sp_o, sp_m = SP_RST;
  logic [35:0] exp_q[$];
  logic [31:0] rs = 32'd81022;
  int bad_count = 0, cmp_count = 0;
  ret_rot_exec #(.DEPTH(STACK_DEPTH)) DUT (.clk_i, .srst_i, .instr_i, .instr_valid_i,
    .file_rdata_i(fmem[file_addr_o]), .push_i, .push_addr_i, .instr_ready_o, .file_addr_o,
    .file_we_o, .file_wdata_o, .acc_o, .carry_o, .pc_o, .pc_load_o, .sp_o);
  prog_mem_model PM (.clk_i, .srst_i, .ready_i(instr_ready_o), .stall_i, .instr_o(instr_i),
    .valid_o(instr_valid_i));
  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  task end_of_test();
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // ==========
  // Clock
  initial forever #5 clk_i = ~clk_i;
  // Note each taken instruction, compare at the following falling edge
  always @(posedge clk_i) took <= instr_valid_i && instr_ready_o && !srst_i;
  always @(negedge clk_i) if (took) begin : mon
    logic [35:0] e, a;
    e = exp_q.pop_front();
    a = {acc_o, carry_o, pc_o, pc_load_o, file_we_o, file_we_o ? file_wdata_o : 8'h00, sp_o, instr_ready_o};
    cmp_count++;
    if (a !== e) begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  end
  // Reset, stack preload, random program with stalls
  initial begin
    int i, n, kind;
    logic [13:0] w;
    logic [7:0] v, r;
    logic d, l, rt;
    logic [6:0] f;
    n = 0;
    foreach (fmem[j]) fmem[j] = 8'(xs());
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 6; i++) begin
      stk[sp_m] = 13'(xs());
      push_addr_i <= stk[sp_m];
      push_i <= 1'b1;
      sp_m++;
      @(posedge clk_i);
    end
    push_i <= 1'b0;
    for (i = 0; i < 40; i++) begin
      kind = int'(xs() % 4);
      rt = kind > 1 && n < 6;
      l = kind[0];
      d = 1'(xs());
      v = 8'(xs());
      f = 7'(xs());
      if (rt) begin
        n++;
        sp_m--;
        pc_m = stk[sp_m];
        if (kind == 2) acc_m = v;
        w = kind == 2 ? {OPC_RETIMM_HI, 2'b00, v} : OPC_RETURN;
        r = 8'h00;
        d = 1'b0;
      end else begin
        r = l ? {fmem[f][6:0], carry_m} : {carry_m, fmem[f][7:1]};
        carry_m = l ? fmem[f][7] : fmem[f][0];
        if (!d) begin
          acc_m = r;
          r = 8'h00;
        end
        w = {l ? OPC_ROTL : OPC_ROTR, d, f};
      end
      exp_q.push_back({acc_m, carry_m, pc_m, rt, d, r, sp_m, !rt});
      PM.words.push_back(w);
    end
    for (i = 0; i < 600 && exp_q.size() > 0; i++) begin
      stall_i <= 1'(xs());
      @(posedge clk_i);
    end
    if (exp_q.size() > 0) begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, 0, exp_q.size());
    end
    end_of_test();
  end
endmodule : ret_rot_exec_tb_top
